// File: rtl/cwlo_chan.sv
// one channel: rotated 16-state divider and retimed i/q flip-flops
`timescale 1ns/1ns
module cwlo_chan
	import cwlo_pkg::*;
(
	input  wire logic                    mclk,
	input  wire logic                    sys_rst,
	input  wire logic                    clk_en,
	input  wire logic                    div_sync,
	input  wire logic [3:0]              step,
	input  wire logic [CWLO_PHASE_W-1:0] phase,
	output logic                         lo_i,
	output logic                         lo_q
);

	logic [3:0] count;
	logic [3:0] next_count;
	logic [3:0] rot_state;
	logic [3:0] quad_state;

	// sync pulse parks the sequence at zero
	assign next_count = div_sync ? CWLO_COUNT_RST : 4'(count + step);
	// phase code offsets the state sequence
	assign rot_state  = 4'(count + phase);
	assign quad_state = 4'(rot_state + CWLO_QUAD_OFS); // quarter turn

	// divider chain state
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			count <= CWLO_COUNT_RST;
		else if (clk_en)
			count <= next_count;
	end

	// final flops on the lo clock itself keep adder glitches off the
	// outputs; msb of a 16-state wrap is high for exactly half
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			lo_i <= 1'b0;
			lo_q <= 1'b0;
		end else if (clk_en) begin
			lo_i <= rot_state[3];
			lo_q <= quad_state[3];
		end
	end

endmodule // cwlo_chan

// File: rtl/cwlo_divider.sv
// cw lo quadrature divider top: reset conditioning and channel array
// Summary of operation
// - lo phases come from dividing the lo clock by 4, 8 or 16
// - a 3-bit select field picks the division factor
// - final lo flip-flops are clocked directly by the lo clock
// - divide-by-4 and divide-by-8 outputs have 50 percent duty
// - a rising edge on the divider reset returns dividers to zero
// - divider reset may be sampled on rising or falling lo edge
// - each channel holds a 4-bit phase code of 22.5 degree steps
// - in divide-by-16 a code one higher leads by 22.5 degrees; equal codes in phase
`timescale 1ns/1ns
module cwlo_divider
	import cwlo_pkg::*;
#(
	parameter int NUM_CH = 8
) (
	input  wire logic                           mclk,
	input  wire logic                           sys_rst,
	input  wire logic                           clk_en,
	input  wire logic                           div_rst_pin,
	input  wire logic                           rst_edge_sel,
	input  wire logic [CWLO_MODE_W-1:0]         div_mode,
	input  wire logic [NUM_CH*CWLO_PHASE_W-1:0] phase_code,
	output logic      [NUM_CH-1:0]              lo_i_out,
	output logic      [NUM_CH-1:0]              lo_q_out,
	output logic                                div_sync_pulse
);

	logic [CWLO_SYNC_STAGES-1:0] rise_sync;
	logic [CWLO_SYNC_STAGES-1:0] fall_sync;
	logic                        rst_level;
	logic                        next_rst_level;
	logic                        rise_agree;
	logic                        fall_agree;
	logic [3:0]                  div_step;
	logic                        divide_by_four_mode;
	logic                        divide_by_eight_mode;
	logic                        divide_by_sixteen_mode;

	// rising-edge sampler; stage 0 feeds stage 1 only
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			rise_sync <= '0;
		else if (clk_en)
			rise_sync <= {rise_sync[1:0], div_rst_pin};
	end

	// falling-edge sampler, for a reset aligned to the rising edge
	always_ff @(negedge mclk or posedge sys_rst) begin
		if (sys_rst)
			fall_sync <= '0;
		else if (clk_en)
			fall_sync <= {fall_sync[1:0], div_rst_pin};
	end

	// a level counts once the last two stages agree
	assign rise_agree     = rise_sync[1] == rise_sync[2];
	assign fall_agree     = fall_sync[1] == fall_sync[2];
	assign next_rst_level = (rst_edge_sel == CWLO_EDGE_FALL) ?
		(fall_agree ? fall_sync[2] : rst_level) :
		(rise_agree ? rise_sync[2] : rst_level);

	// edge-triggered: only the low-to-high change resets, so a reset
	// toggling at the lo rate re-aligns every period
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rst_level      <= 1'b0;
			div_sync_pulse <= 1'b0;
		end else if (clk_en) begin
			rst_level      <= next_rst_level;
			div_sync_pulse <= next_rst_level & ~rst_level;
		end
	end

	// division select decode; unused codes fall back to divide-by-4
	assign divide_by_eight_mode   = div_mode == CWLO_MODE_DIV8;
	assign divide_by_sixteen_mode = div_mode == CWLO_MODE_DIV16;
	assign divide_by_four_mode    = ~divide_by_eight_mode &
	                                ~divide_by_sixteen_mode;
	assign div_step = divide_by_sixteen_mode ? CWLO_STEP_DIV16 :
	                  divide_by_eight_mode   ? CWLO_STEP_DIV8  :
	                                           CWLO_STEP_DIV4;

	// one divider per channel, all released by the same pulse so equal
	// codes stay in phase
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
		cwlo_chan u_chan (
			.mclk     (mclk),
			.sys_rst  (sys_rst),
			.clk_en   (clk_en),
			.div_sync (div_sync_pulse),
			.step     (div_step),
			.phase    (phase_code[ch*CWLO_PHASE_W +: CWLO_PHASE_W]),
			.lo_i     (lo_i_out[ch]),
			.lo_q     (lo_q_out[ch])
		);
	end

	// helper: cycles since anything disturbed the steady pattern
	logic [4:0]                        quiet_cnt;
	logic [CWLO_MODE_W-1:0]            mode_prev;
	logic [NUM_CH*CWLO_PHASE_W-1:0]    code_prev;
	logic                              disturb;
	logic                              steady;
	logic [3:0]                        code0;
	logic [3:0]                        code1;

	assign code0   = phase_code[3:0];
	assign code1   = phase_code[7:4];
	assign disturb = ~clk_en | div_sync_pulse | (div_mode != mode_prev) |
	                 (phase_code != code_prev);
	assign steady  = quiet_cnt >= 5'h14;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			quiet_cnt <= 5'h00;
			mode_prev <= '0;
			code_prev <= '0;
		end else begin
			mode_prev <= div_mode;
			code_prev <= phase_code;
			if (disturb)
				quiet_cnt <= 5'h00;
			else if (quiet_cnt != 5'h1F)
				quiet_cnt <= 5'(quiet_cnt + 5'h01);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	div_four_period_a: assert property (disable iff (sys_rst || disturb)
		(steady && divide_by_four_mode) |-> lo_i_out[0] == $past(lo_i_out[0], 4))
		else $error("divide-by-4 period wrong");
	div_eight_period_a: assert property (disable iff (sys_rst || disturb)
		(steady && divide_by_eight_mode) |-> (lo_i_out[0] == $past(lo_i_out[0], 8))
		&& (lo_i_out[0] != $past(lo_i_out[0], 4)))
		else $error("divide-by-8 period wrong");
	div_sixteen_period_a: assert property (disable iff (sys_rst || disturb)
		(steady && divide_by_sixteen_mode) |->
		(lo_i_out[0] == $past(lo_i_out[0], 16)) &&
		(lo_i_out[0] != $past(lo_i_out[0], 8)))
		else $error("divide-by-16 period wrong");
	four_duty_a: assert property (disable iff (sys_rst || disturb)
		(steady && divide_by_four_mode && $rose(lo_i_out[0])) |=>
		lo_i_out[0] ##1 !lo_i_out[0] ##1 !lo_i_out[0])
		else $error("divide-by-4 duty not half");
	eight_duty_a: assert property (disable iff (sys_rst || disturb)
		(steady && divide_by_eight_mode && $rose(lo_i_out[0])) |=>
		lo_i_out[0] [*3] ##1 !lo_i_out[0] [*4])
		else $error("divide-by-8 duty not half");
	quad_offset_a: assert property (disable iff (sys_rst || disturb)
		(steady && divide_by_sixteen_mode) |-> lo_i_out[0] == $past(lo_q_out[0], 4))
		else $error("q not a quarter period ahead of i");
	sync_restart_a: assert property (
		(div_sync_pulse && clk_en) ##1 (clk_en && $stable(code0)) |=>
		(lo_i_out[0] == code0[3]) && (lo_q_out[0] == 4'(code0 + 4'h4) >> 3))
		else $error("channel did not restart at rotated state");
	sync_edge_a: assert property (
		$rose(div_sync_pulse) |-> rst_level && !$past(rst_level))
		else $error("sync pulse without rising reset edge");
	edge_select_a: assert property (
		(clk_en && rst_edge_sel == CWLO_EDGE_FALL && fall_agree &&
		fall_sync[2] && !rst_level) |=> div_sync_pulse)
		else $error("falling-edge sampled reset missed");
	code_lead_a: assert property (disable iff (sys_rst || disturb)
		(steady && divide_by_sixteen_mode && code1 == 4'(code0 + 4'h1)) |->
		lo_i_out[0] == $past(lo_i_out[1]))
		else $error("higher code does not lead by one step");
	equal_phase_a: assert property (disable iff (sys_rst || disturb)
		(steady && code0 == code1) |->
		lo_i_out[0] == lo_i_out[1] && lo_q_out[0] == lo_q_out[1])
		else $error("equal codes not in phase");

	cov_sync_div4_c:  cover property (div_sync_pulse && divide_by_four_mode);
	cov_sync_div16_c: cover property (div_sync_pulse && divide_by_sixteen_mode);
	cov_fall_edge_c:  cover property (div_sync_pulse &&
		rst_edge_sel == CWLO_EDGE_FALL);
	cov_lead_c:       cover property (steady && divide_by_eight_mode &&
		code1 == 4'(code0 + 4'h2));

endmodule // cwlo_divider

// File: rtl/cwlo_pkg.sv
// constants for the cw local-oscillator quadrature divider
package cwlo_pkg;

	// configuration locations (no software bus; kept for cross-reference)
	localparam logic [11:0] CWLO_DIV_CFG_ADDR   = 12'h02E;
	localparam logic [11:0] CWLO_PHASE_ADDR     = 12'h02D;

	// divide-select field layout and encodings
	localparam int          CWLO_MODE_LSB       = 0;
	localparam int          CWLO_MODE_W         = 3;
	localparam logic [2:0]  CWLO_MODE_DIV4      = 3'h0;
	localparam logic [2:0]  CWLO_MODE_DIV8      = 3'h1;
	localparam logic [2:0]  CWLO_MODE_DIV16     = 3'h2;

	// phase code field layout
	localparam int          CWLO_PHASE_LSB      = 0;
	localparam int          CWLO_PHASE_W        = 4;
	localparam logic [3:0]  CWLO_PHASE_RST      = 4'h0;

	// 16-state sequence; step per cycle sets the division factor
	localparam logic [3:0]  CWLO_STEP_DIV4      = 4'h4;
	localparam logic [3:0]  CWLO_STEP_DIV8      = 4'h2;
	localparam logic [3:0]  CWLO_STEP_DIV16     = 4'h1;
	localparam logic [3:0]  CWLO_COUNT_RST      = 4'h0;
	localparam logic [3:0]  CWLO_QUAD_OFS       = 4'h4;

	// divider reset input conditioning
	localparam int          CWLO_SYNC_STAGES    = 3;
	localparam logic        CWLO_EDGE_RISE      = 1'b0;
	localparam logic        CWLO_EDGE_FALL      = 1'b1;

	// lo periods in clock cycles
	localparam int          CWLO_PER_DIV4       = 4;
	localparam int          CWLO_PER_DIV8       = 8;
	localparam int          CWLO_PER_DIV16      = 16;

endpackage

// File: verif/cwlo_divider_bench.sv
// self-checking bench for the cw lo quadrature divider
`timescale 1ns/1ns
module cwlo_divider_bench
	import cwlo_pkg::*;
();
	localparam int NCH = 4;
	typedef struct packed {
		logic [2:0]  mode;
		logic        edge_s;
		logic [15:0] codes;
		logic [NCH-1:0] i0;
	} cwlo_row_t;
	logic           mclk = 1'b0;
	logic           sys_rst = 1'b1;
	logic           clk_en = 1'b1;
	logic           rst_edge_sel = 1'b0;
	logic           run_cont = 1'b0;
	logic [2:0]     div_mode = CWLO_MODE_DIV4;
	logic [15:0]    phase_code = 16'h0000;
	logic           div_rst_pin;
	logic           div_sync_pulse;
	logic [NCH-1:0] lo_i_out;
	logic [NCH-1:0] lo_q_out;
	logic [NCH-1:0] hold_i;
	logic [NCH-1:0] hold_q;
	int             n_errors = 0;
	int             cmp_count = 0;
	int             cycles = 0;
	int             hits;
	// equal codes in row 3 must give matching channels; i0 is the i
	// pattern right after resync (codes of half a turn or more start high)
	cwlo_row_t rows [6] = '{'{3'h0, 1'b0, 16'h6420, 4'h0},
		'{3'h1, 1'b0, 16'h3210, 4'h0}, '{3'h2, 1'b0, 16'hF510, 4'h8},
		'{3'h2, 1'b1, 16'h1100, 4'h0}, '{3'h1, 1'b1, 16'hEC84, 4'hE},
		'{3'h3, 1'b0, 16'hA8E0, 4'hE}}; // even codes in div4

	cwlo_divider #(.NUM_CH(NCH)) i_dut (
		.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
		.div_rst_pin(div_rst_pin), .rst_edge_sel(rst_edge_sel),
		.div_mode(div_mode), .phase_code(phase_code),
		.lo_i_out(lo_i_out), .lo_q_out(lo_q_out),
		.div_sync_pulse(div_sync_pulse));
	cwlo_sync_src src (.mclk(mclk), .edge_sel(rst_edge_sel),
		.run_cont(run_cont), .half_per(5'h04),
		.div_rst_pin(div_rst_pin));

	// clock and hang guard
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [3:0] got, input logic [3:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask

	// wait for a resync, then step the 16-state sequence per channel
	task automatic check_wave(input logic [2:0] m, input logic [15:0] c,
		input logic [NCH-1:0] i0);
		logic [NCH-1:0] ei;
		logic [NCH-1:0] eq;
		int             per;
		int             ph;
		int             w;
		per = (m == CWLO_MODE_DIV8) ? CWLO_PER_DIV8 :
			(m == CWLO_MODE_DIV16) ? CWLO_PER_DIV16 : CWLO_PER_DIV4;
		w = 0;
		while (div_sync_pulse !== 1'b1 && w < 40) begin
			@(posedge mclk);
			#1;
			w++;
		end
		chk(div_sync_pulse, 1'b1, "no resync");
		@(posedge mclk);
		for (int n = 0; n < 32; n++) begin
			@(posedge mclk);
			#1;
			// phase in sixteenths of a turn: elapsed time plus code;
			// i is high for the second half turn, q a quarter ahead
			for (int ch = 0; ch < NCH; ch++) begin
				ph = (n * 16 / per + int'(c[4*ch +: 4])) % 16;
				ei[ch] = ph >= 8;
				eq[ch] = (ph + 4) % 16 >= 8;
			end
			if (n == 0) chk(lo_i_out, i0, "first i");
			chk(lo_i_out, ei, "i phase");
			chk(lo_q_out, eq, "q phase");
		end
	endtask

	task report_and_stop;
		$display("%0d compares, %0d mismatches", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge mclk);
		#1;
		chk(lo_i_out | lo_q_out, 4'h0, "reset outputs");
		chk(div_sync_pulse, 1'b0, "reset pulse");
		@(posedge mclk);
		sys_rst <= 1'b0;
		$display("test reset done");
		// table rows: every mode and both sampling edges
		foreach (rows[r]) begin
			@(posedge mclk);
			div_mode <= rows[r].mode;
			rst_edge_sel <= rows[r].edge_s;
			phase_code <= rows[r].codes;
			repeat (8) @(posedge mclk);
			#1;
			fork
				src.pulse(4);
				check_wave(rows[r].mode, rows[r].codes, rows[r].i0);
			join
			$display("test row %0d done", r);
		end
		// held-high pin: fixed latency and a single resync only
		@(posedge mclk);
		fork
			src.pulse(20);
			begin
				@(negedge mclk);
				hits = 0;
				for (int e = 0; e < 24; e++) begin
					@(posedge mclk);
					#1;
					if (e == 3) chk(div_sync_pulse, 1'b1, "latency");
					hits += div_sync_pulse;
				end
			end
		join
		chk(hits[3:0], 4'h1, "held high");
		$display("test held pin done");
		// continuous reset at the lo rate must not disturb the phases
		@(posedge mclk);
		div_mode <= CWLO_MODE_DIV8;
		phase_code <= 16'h6420;
		run_cont <= 1'b1;
		#1;
		check_wave(CWLO_MODE_DIV8, 16'h6420, 4'h0);
		@(posedge mclk);
		run_cont <= 1'b0;
		$display("test continuous done");
		// low enable freezes the outputs
		@(posedge mclk);
		clk_en <= 1'b0;
		@(posedge mclk);
		#1;
		hold_i = lo_i_out;
		hold_q = lo_q_out;
		repeat (6) @(posedge mclk);
		#1;
		chk(lo_i_out, hold_i, "freeze i");
		chk(lo_q_out, hold_q, "freeze q");
		@(posedge mclk);
		clk_en <= 1'b1;
		$display("test freeze done");
		report_and_stop();
	end
endmodule // cwlo_divider_bench

// File: verif/cwlo_sync_src.sv
// divider reset source model: single pulses or a lo-rate square wave
`timescale 1ns/1ns
module cwlo_sync_src (
	input  wire logic       mclk,
	input  wire logic       edge_sel,
	input  wire logic       run_cont,
	input  wire logic [4:0] half_per,
	output logic            div_rst_pin
);
	int k = 0;

	// pin idles low, as an unused reset input is tied low
	initial div_rst_pin = 1'b0;

	// launch on the edge opposite the sampling one for margin
	always @(posedge mclk or negedge mclk) begin
		if (mclk === edge_sel && run_cont) begin
			k = (k + 1) % half_per;
			if (k == 0) div_rst_pin <= ~div_rst_pin;
		end else if (!run_cont) begin
			k = 0;
		end
	end

	// one pulse of len cycles, aligned to the launch edge
	task automatic pulse(input int len);
		if (edge_sel) @(posedge mclk);
		else @(negedge mclk);
		div_rst_pin <= 1'b1;
		repeat (len) begin
			if (edge_sel) @(posedge mclk);
			else @(negedge mclk);
		end
		div_rst_pin <= 1'b0;
	endtask
endmodule // cwlo_sync_src
